// ==== src/kbi_ctrl.v ====
// keyboard and external interrupt control with a wishbone register port
//
// The register addresses and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "kbi_consts.vh"

// Summary of operation
// - ext pending flag reads 1 while external interrupt pending
// - writing 1 to ext ack clears external latch; reads 0
// - ext mask 1 blocks external request to CPU; read/write, reset 0
// - ext level sense 1: falling edge and low level; 0: edge only
// - key pending flag reads 1 while keyboard interrupt pending
// - writing 1 to key ack clears keyboard request; reads 0
// - key mask 1 stops keyboard requests to CPU
// - key level sense 1: edge and level; 0: falling edge only
// - six enable bits; disabled pins never contribute
// - pullup on only while the pin's enable bit is 1
// - set enable forces pin to input over direction register
// - reset clears all enable bits
// - keyboard latch sets when enabled pins fall after all high
// - level mode clears after both acknowledge and all pins high
// - edge mode clears at once on acknowledge
// - in break without clear enable, ack writes do nothing
module kbi_ctrl (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // wishbone slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [4:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   // pins and port
   input wire ext_int_pin_i,
   input wire [5:0] port_pin_x_i,
   input wire [5:0] ddr_i,
   output reg [5:0] pullup_en_o,
   output reg [5:0] ddr_eff_o,
   output reg [5:0] read_en_o,
   // cpu and system
   input wire ext_vec_fetch_i,
   input wire key_vec_fetch_i,
   input wire break_i,
   input wire break_clear_enable_i,
   output reg ext_irq_o,
   output reg key_irq_o,
   output reg ext_vec_ack_o,
   output reg key_vec_ack_o,
   output reg irq_o
);
   reg ext_mask_reg;
   reg ext_level_sense_reg;
   reg key_mask_reg;
   reg key_level_sense_reg;
   reg [5:0] key_pin_enables_reg;
   reg [1:0] ev_stat_reg;
   reg [1:0] ev_en_reg;
   reg ext_pend_d_reg;
   reg key_pend_d_reg;
   reg [31:0] rdata_next;
   wire ext_pin_s;
   wire [5:0] key_pin_s;
   wire key_low;
   wire ext_pending_flag;
   wire key_pending_flag;
   wire wr_stb;
   wire ack_allowed;
   wire ext_ack;
   wire key_ack;
   wire [1:0] ev_set;

   // ---------------------------------------------------------------
   // address decode helper
   // ---------------------------------------------------------------
   function hit;
      input [4:0] a;
      input p;
      input [3:0] ofs;
      begin
         hit = (a[`KBI_PAGE_BIT] == p) && (a[3:0] == ofs);
      end
   endfunction

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   kbi_sync #(.W(1)) u_sync_ext (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(ext_int_pin_i),
      .q_o(ext_pin_s)
   );

   kbi_sync #(.W(`KBI_NKEY)) u_sync_key (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(port_pin_x_i),
      .q_o(key_pin_s)
   );

   // any enabled pin low; disabled pins ignored
   assign key_low = |(~key_pin_s & key_pin_enables_reg);

   // ---------------------------------------------------------------
   // acknowledge sources
   // ---------------------------------------------------------------
   assign wr_stb = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];
   assign ack_allowed = ~break_i | break_clear_enable_i;
   assign ext_ack = ext_vec_fetch_i |
      (wr_stb & hit(adr_i, 1'b0, `KBI_OFS_SCR) & dat_i[`KBI_SCR_EXT_ACK]
       & ack_allowed);
   assign key_ack = key_vec_fetch_i |
      (wr_stb & hit(adr_i, 1'b0, `KBI_OFS_SCR) & dat_i[`KBI_SCR_KEY_ACK]
       & ack_allowed);

   // ---------------------------------------------------------------
   // latches
   // ---------------------------------------------------------------
   kbi_latch u_ext_latch (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .low_i(~ext_pin_s),
      .level_i(ext_level_sense_reg),
      .ack_i(ext_ack),
      .pend_o(ext_pending_flag)
   );

   kbi_latch u_key_latch (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .low_i(key_low),
      .level_i(key_level_sense_reg),
      .ack_i(key_ack),
      .pend_o(key_pending_flag)
   );

   // ---------------------------------------------------------------
   // control registers
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         ext_mask_reg <= 1'b0;
         ext_level_sense_reg <= 1'b0;
         key_mask_reg <= 1'b0;
         key_level_sense_reg <= 1'b0;
         key_pin_enables_reg <= `KBI_RST_KIE;
         ev_en_reg <= `KBI_RST_EV;
      end else if (wr_stb) begin
         if (hit(adr_i, 1'b0, `KBI_OFS_SCR)) begin
            ext_mask_reg <= dat_i[`KBI_SCR_EXT_MASK];
            ext_level_sense_reg <= dat_i[`KBI_SCR_EXT_LVL];
            key_mask_reg <= dat_i[`KBI_SCR_KEY_MASK];
            key_level_sense_reg <= dat_i[`KBI_SCR_KEY_LVL];
         end
         if (hit(adr_i, 1'b0, `KBI_OFS_KIE)) begin
            key_pin_enables_reg <= dat_i[5:0];
         end
         if (hit(adr_i, 1'b1, `KBI_OFS_IEN)) begin
            ev_en_reg <= dat_i[1:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // sticky event status: set on rising pending, set wins over clear
   // ---------------------------------------------------------------
   assign ev_set = {key_pending_flag & ~key_pend_d_reg,
                    ext_pending_flag & ~ext_pend_d_reg};

   always @(posedge clk_i) begin
      if (rst_i) begin
         ev_stat_reg <= `KBI_RST_EV;
         ext_pend_d_reg <= 1'b0;
         key_pend_d_reg <= 1'b0;
      end else begin
         ext_pend_d_reg <= ext_pending_flag;
         key_pend_d_reg <= key_pending_flag;
         if (wr_stb && hit(adr_i, 1'b0, `KBI_OFS_ICL)) begin
            ev_stat_reg <= (ev_stat_reg & ~dat_i[1:0]) | ev_set;
         end else begin
            ev_stat_reg <= ev_stat_reg | ev_set;
         end
      end
   end

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   always @* begin
      rdata_next = 32'h00000000;
      if (hit(adr_i, 1'b0, `KBI_OFS_SCR)) begin
         rdata_next[`KBI_SCR_EXT_FLAG] = ext_pending_flag;
         rdata_next[`KBI_SCR_EXT_MASK] = ext_mask_reg;
         rdata_next[`KBI_SCR_EXT_LVL] = ext_level_sense_reg;
         rdata_next[`KBI_SCR_KEY_FLAG] = key_pending_flag;
         rdata_next[`KBI_SCR_KEY_MASK] = key_mask_reg;
         rdata_next[`KBI_SCR_KEY_LVL] = key_level_sense_reg;
      end else if (hit(adr_i, 1'b0, `KBI_OFS_KIE)) begin
         rdata_next[5:0] = key_pin_enables_reg;
      end else if (hit(adr_i, 1'b0, `KBI_OFS_IST)) begin
         rdata_next[1:0] = ev_stat_reg;
      end else if (hit(adr_i, 1'b1, `KBI_OFS_IEN)) begin
         rdata_next[1:0] = ev_en_reg;
      end
   end

   // ---------------------------------------------------------------
   // bus answer and registered outputs
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
         pullup_en_o <= 6'h00;
         ddr_eff_o <= 6'h00;
         read_en_o <= 6'h00;
         ext_irq_o <= 1'b0;
         key_irq_o <= 1'b0;
         ext_vec_ack_o <= 1'b0;
         key_vec_ack_o <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         ack_o <= cyc_i & stb_i & ~ack_o;
         dat_o <= rdata_next;
         pullup_en_o <= key_pin_enables_reg;
         ddr_eff_o <= ddr_i & ~key_pin_enables_reg;
         read_en_o <= ~ddr_i;
         ext_irq_o <= ext_pending_flag & ~ext_mask_reg;
         key_irq_o <= key_pending_flag & ~key_mask_reg;
         ext_vec_ack_o <= ext_vec_fetch_i;
         key_vec_ack_o <= key_vec_fetch_i;
         irq_o <= |(ev_stat_reg & ev_en_reg);
      end
   end
endmodule
`default_nettype wire

// ==== src/kbi_consts.vh ====
// constants for the keyboard and external interrupt control block
`ifndef KBI_CONSTS_VH
`define KBI_CONSTS_VH

// ---------------------------------------------------------------
// register word offsets (byte addresses, chosen)
// ---------------------------------------------------------------
`define KBI_OFS_SCR 4'h0
`define KBI_OFS_KIE 4'h4
`define KBI_OFS_IST 4'h8
`define KBI_OFS_ICL 4'hC
`define KBI_OFS_IEN 4'h0
// second page selector: address bit 4
`define KBI_PAGE_BIT 4

// ---------------------------------------------------------------
// status and control field positions
// ---------------------------------------------------------------
`define KBI_SCR_EXT_FLAG 7
`define KBI_SCR_EXT_ACK 6
`define KBI_SCR_EXT_MASK 5
`define KBI_SCR_EXT_LVL 4
`define KBI_SCR_KEY_FLAG 3
`define KBI_SCR_KEY_ACK 2
`define KBI_SCR_KEY_MASK 1
`define KBI_SCR_KEY_LVL 0

// ---------------------------------------------------------------
// event status bit positions
// ---------------------------------------------------------------
`define KBI_EV_EXT 0
`define KBI_EV_KEY 1

// ---------------------------------------------------------------
// widths and reset values
// ---------------------------------------------------------------
`define KBI_NKEY 6
`define KBI_RST_SCR 8'h00
`define KBI_RST_KIE 6'h00
`define KBI_RST_EV 2'h0

`endif

// ==== src/kbi_sync.v ====
// two flip-flop synchroniser for a bus of pins
`timescale 1ns/1ps
`default_nettype none
module kbi_sync #(
   parameter W = 1
) (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // pins
   input wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);
   reg [W-1:0] s1_reg;
   reg [W-1:0] s2_reg;

   // reset to idle-high so a pin at rest sets nothing
   always @(posedge clk_i) begin
      if (rst_i) begin
         s1_reg <= {W{1'b1}};
         s2_reg <= {W{1'b1}};
      end else begin
         s1_reg <= d_i;
         s2_reg <= s1_reg;
      end
   end
   assign q_o = s2_reg;
endmodule
`default_nettype wire

// ==== src/kbi_latch.v ====
// one interrupt latch with edge or edge-and-level triggering
`timescale 1ns/1ps
`default_nettype none
module kbi_latch (
   // clock and reset
   input wire clk_i,
   input wire rst_i,
   // condition
   input wire low_i,
   input wire level_i,
   input wire ack_i,
   // state
   output wire pend_o
);
   reg low_d_reg;
   reg pend_reg;
   reg acked_reg;
   wire fall;

   assign fall = low_i & ~low_d_reg;

   always @(posedge clk_i) begin
      if (rst_i) begin
         low_d_reg <= 1'b0;
         pend_reg <= 1'b0;
         acked_reg <= 1'b0;
      end else begin
         low_d_reg <= low_i;
         if (fall) begin
            // a new falling edge wins over a clear in the same cycle
            pend_reg <= 1'b1;
            acked_reg <= 1'b0;
         end else if (level_i) begin
            // both ack and return high needed, any order
            if (pend_reg & (ack_i | acked_reg) & ~low_i) begin
               pend_reg <= 1'b0;
               acked_reg <= 1'b0;
            end else if (pend_reg & ack_i) begin
               acked_reg <= 1'b1;
            end
         end else if (ack_i) begin
            pend_reg <= 1'b0;
            acked_reg <= 1'b0;
         end
      end
   end
   assign pend_o = pend_reg;
endmodule
`default_nettype wire

// ==== bench/kbi_pins_model.sv ====
// switch and external line model for the interrupt pins
`timescale 1ns/1ps
`default_nettype none
module kbi_pins_model (
   // clock
   input wire logic clk_i,
   // switches and pullups
   input wire logic [5:0] press_i,
   input wire logic ext_low_i,
   input wire logic [5:0] pullup_en_i,
   // pins
   output wire logic [5:0] port_pin_x_o,
   output wire logic ext_int_pin_o
);
   logic [5:0] float_reg = 6'h00;
   // a released pin without pullup floats: shown as a toggling level
   always @(posedge clk_i) float_reg <= ~float_reg;
   assign port_pin_x_o = ~press_i & (pullup_en_i | float_reg);
   assign ext_int_pin_o = ~ext_low_i;
endmodule
`default_nettype wire

// ==== bench/kbi_ctrl_sva.sv ====
// port assertions for the keyboard interrupt block
`timescale 1ns/1ps
`default_nettype none
module kbi_ctrl_sva (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [4:0] adr_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   // port and cpu
   input wire logic [5:0] ddr_i,
   input wire logic [5:0] pullup_en_o,
   input wire logic [5:0] ddr_eff_o,
   input wire logic [5:0] read_en_o,
   input wire logic ext_vec_fetch_i,
   input wire logic key_vec_fetch_i,
   input wire logic ext_vec_ack_o,
   input wire logic key_vec_ack_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire req = cyc_i && stb_i && !ack_o;
   wire rd0 = cyc_i && stb_i && !we_i && adr_i == 5'h00;
   wire wr4 = ack_o && we_i && adr_i == 5'h04;
   a_ack_follows_req: assert property (req |=> ack_o) else $error("request not acked");
   a_ack_one_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
   a_ack_bits_zero: assert property (ack_o && $past(rd0) |-> !dat_o[6] && !dat_o[2])
      else $error("ack bit read back");
   a_unmapped_zero: assert property (ack_o && $past(!we_i && adr_i == 5'h14) |-> dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_ext_vec_ack: assert property (!$past(rst_i) |-> ext_vec_ack_o == $past(ext_vec_fetch_i))
      else $error("ext vector ack");
   a_key_vec_ack: assert property (!$past(rst_i) |-> key_vec_ack_o == $past(key_vec_fetch_i))
      else $error("key vector ack");
   a_dir_forced: assert property (!$past(rst_i) |-> ddr_eff_o == ($past(ddr_i) & ~pullup_en_o))
      else $error("direction not forced");
   a_read_enable: assert property (!$past(rst_i) |-> read_en_o == ~$past(ddr_i))
      else $error("read enable wrong");
   a_pullup_steady: assert property ($changed(pullup_en_o) |-> $past(wr4))
      else $error("pullup moved without write");
endmodule
bind kbi_ctrl kbi_ctrl_sva i_kbi_ctrl_sva (.*);
`default_nettype wire

// ==== bench/tb_top.sv ====
// self-checking bench for the keyboard interrupt block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o;
   logic [4:0] adr_i = 5'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, q;
   logic ext_int_pin_i, ext_low = 1'b0, ext_vec_fetch_i = 1'b0, key_vec_fetch_i = 1'b0;
   logic break_i = 1'b0, break_clear_enable_i = 1'b0, ext_vec_ack_o, key_vec_ack_o;
   logic [5:0] port_pin_x_i, press = 6'h00, ddr_i = 6'h00, pullup_en_o, ddr_eff_o;
   logic [5:0] read_en_o, en, p;
   logic ext_irq_o, key_irq_o, irq_o;
   integer n_errors = 0, n_tests = 0, seed = 32'hc377;
   always #5 clk_i = ~clk_i;
   kbi_ctrl i_kbi_ctrl (.*);
   kbi_pins_model i_kbi_pins_model (.clk_i(clk_i), .press_i(press), .ext_low_i(ext_low),
      .pullup_en_i(pullup_en_o), .port_pin_x_o(port_pin_x_i), .ext_int_pin_o(ext_int_pin_i));
   function automatic logic [7:0] scr(input logic ef, em, el, kf, km, kl);
      return {ef, 1'b0, em, el, kf, 1'b0, km, kl};
   endfunction
   task automatic test_done();
      if (n_errors == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic idle(input integer c);
      repeat (c) @(posedge clk_i);
   endtask
   task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
      integer k;
      k = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= 4'hF;
      dat_i <= {24'h0, d};
      @(posedge clk_i);
      while (ack_o !== 1'b1 && k < 20) begin
         @(posedge clk_i);
         k++;
      end
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
      if (k == 20) begin
         n_errors++;
         test_done();
      end
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      chk(q, {24'h0, e});
   endtask
   initial begin
      idle(16);
      rst_i <= 1'b0;
      ddr_i <= 6'($random(seed));
      en = 6'($random(seed) | 6'h01) & 6'h1F;
      p = (en & 6'($random(seed))) | 6'h01;
      @(posedge clk_i);
      rd(5'h00, scr(0, 0, 0, 0, 0, 0));
      rd(5'h04, 8'h00);
      rd(5'h14, 8'h00);
      ext_low <= 1'b1;
      idle(6);
      rd(5'h00, scr(1, 0, 0, 0, 0, 0));
      chk(ext_irq_o, 1'b1);
      wb(1'b1, 5'h00, 8'h20);
      idle(2);
      chk(ext_irq_o, 1'b0);
      wb(1'b1, 5'h00, 8'h60);
      rd(5'h00, scr(0, 1, 0, 0, 0, 0));
      ext_low <= 1'b0;
      idle(4);
      wb(1'b1, 5'h00, 8'h30);
      ext_low <= 1'b1;
      idle(6);
      wb(1'b1, 5'h00, 8'h70);
      rd(5'h00, scr(1, 1, 1, 0, 0, 0));
      ext_low <= 1'b0;
      idle(6);
      rd(5'h00, scr(0, 1, 1, 0, 0, 0));
      wb(1'b1, 5'h00, 8'h02);
      wb(1'b1, 5'h04, {2'h0, en});
      idle(6);
      chk(pullup_en_o, en);
      wb(1'b1, 5'h00, 8'h06);
      press <= 6'h20;
      idle(6);
      rd(5'h00, scr(0, 0, 0, 0, 1, 0));
      press <= 6'h00;
      wb(1'b1, 5'h00, 8'h00);
      press <= p;
      idle(6);
      rd(5'h00, scr(0, 0, 0, 1, 0, 0));
      chk(key_irq_o, 1'b1);
      break_i <= 1'b1;
      wb(1'b1, 5'h00, 8'h06);
      rd(5'h00, scr(0, 0, 0, 1, 1, 0));
      chk(key_irq_o, 1'b0);
      break_i <= 1'b0;
      key_vec_fetch_i <= 1'b1;
      @(posedge clk_i);
      key_vec_fetch_i <= 1'b0;
      idle(2);
      rd(5'h00, scr(0, 0, 0, 0, 1, 0));
      press <= 6'h00;
      idle(4);
      wb(1'b1, 5'h00, 8'h03);
      press <= p;
      idle(6);
      wb(1'b1, 5'h00, 8'h07);
      rd(5'h00, scr(0, 0, 0, 1, 1, 1));
      press <= 6'h00;
      idle(6);
      rd(5'h00, scr(0, 0, 0, 0, 1, 1));
      rd(5'h08, 8'h03);
      wb(1'b1, 5'h10, 8'h01);
      idle(3);
      chk(irq_o, 1'b1);
      wb(1'b1, 5'h0C, 8'h01);
      idle(3);
      chk(irq_o, 1'b0);
      rd(5'h08, 8'h02);
      ext_low <= 1'b1;
      idle(6);
      ext_vec_fetch_i <= 1'b1;
      @(posedge clk_i);
      ext_vec_fetch_i <= 1'b0;
      idle(2);
      rd(5'h00, scr(0, 0, 0, 0, 1, 1));
      ext_low <= 1'b0;
      idle(4);
      ext_low <= 1'b1;
      idle(6);
      break_i <= 1'b1;
      break_clear_enable_i <= 1'b1;
      wb(1'b1, 5'h00, 8'h43);
      rd(5'h00, scr(0, 0, 0, 0, 1, 1));
      break_i <= 1'b0;
      break_clear_enable_i <= 1'b0;
      rd(5'h08, 8'h03);
      test_done();
   end
endmodule
`default_nettype wire
